/* File: src/csp_slave.sv */
// two-wire control bus slave port with byte-count checked register writes
// Summary of operation
// - slave only, 100 and 400 kHz bus
// - bytes msb first, each byte acknowledged
// - detect start and stop while clock high
// - acknowledge holds data low whole clock
// - address 0x36 or 0x34 from select pin
// - write 0x38 to 0xF9 after unlock at 0xF8 moves address
// - no limit on bytes per transfer
// - low subaddresses single byte, others 4-multiples
// - reads continue while master acknowledges
// - unused read bits return zero
// - short write set discarded at stop/start
// - sequential writes advance subaddress per set
// - only final partial set is dropped
// - write: address, subaddress, data all acknowledged
// - acknowledge every received data byte
// - select pin sampled only after each reset
// - read: subaddress write, restart, nack, stop
`timescale 1ns/1ps
module csp_slave
    import csp_pkg::*;
(
    // system clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_nrst,
    // bus link: clock from the master, open-drain data
    input  wire logic       i_scl_clk,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe_n,
    // address select strap and current bus address
    input  wire logic       i_addr_sel,
    output logic [6:0]      o_bus_addr
);
    csp_state_t      state_q, state_d;
    logic [7:0]      shift_q, shift_d;
    logic            scl_m_q, scl_s_q, scl_p_q;
    logic            sda_m_q, sda_s_q, sda_p_q;
    logic            sel_m_q, sel_s_q;
    logic [3:0]      bit_q, bit_d;
    logic [7:0]      sub_q, sub_d;
    logic [4:0]      bcnt_q, bcnt_d;
    logic            drv_q, drv_d;
    logic            ack_q, ack_d;
    logic [7:0]      tx_q, tx_d;
    logic [6:0]      addr_q, addr_d;
    logic            unlock_q, unlock_d;
    logic [1:0]      strap_q, strap_d;
    logic [159:0]    stage_q, stage_d;
    logic            cmt_q, cmt_d;
    logic [2:0]      cidx_q, cidx_d;
    logic [7:0]      csub_q, csub_d;
    csp_mem_wr_t     mem_wr;
    logic [31:0]     rdata;
    logic [31:0]     cword;
    logic [7:0]      rd_byte;
    logic            scl_rise, scl_fall, start_ev, stop_ev;

    // bytes needed by one data set at a subaddress
    function automatic logic [4:0] set_size(input logic [7:0] sub);
        if (sub <= CSP_SUB_NARROW_END)
            return CSP_SIZE_NARROW;
        else if (sub >= CSP_SUB_BIQUAD_LO && sub <= CSP_SUB_BIQUAD_HI)
            return CSP_SIZE_BIQUAD;
        else
            return CSP_SIZE_WORD;
    endfunction

    // link domain: only the receive shifter runs on the bus clock
    assign shift_d = {shift_q[6:0], i_sda};

    always_ff @(posedge i_scl_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            shift_q <= 8'h00;
        else
            shift_q <= shift_d;
    end

    // pin synchronisers; the shifter is read only after a synced rising
    // clock edge, so its byte has been stable for several system cycles
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
            {sel_m_q, sel_s_q}          <= 2'h0;
        end
        else
        begin
            {scl_m_q, scl_s_q, scl_p_q} <= {i_scl_clk, scl_m_q, scl_s_q};
            {sda_m_q, sda_s_q, sda_p_q} <= {i_sda, sda_m_q, sda_s_q};
            {sel_m_q, sel_s_q}          <= {i_addr_sel, sel_m_q};
        end
    end

    // bus events; conditions are edges of data while clock is high
    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;
    assign start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_ev  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // read byte: bus address register shows zeros above its 7 bits
    always_comb
    begin
        if (sub_q == CSP_SUB_BUS_ADDR)
            rd_byte = (bcnt_q[1:0] == 2'h3) ? {1'b0, addr_q} : 8'h00;
        else if (sub_q <= CSP_SUB_NARROW_END)
            rd_byte = rdata[7:0];
        else
            rd_byte = rdata[(5'd31 - {bcnt_q[1:0], 3'b000}) -: 8];
    end

    // staged word under commit, msb first within the word
    always_comb
    begin
        if (csub_q <= CSP_SUB_NARROW_END)
            cword = {24'h0000_00, stage_q[159:152]};
        else
            cword = stage_q[(8'd159 - {cidx_q, 5'b00000}) -: 32];
    end

    // protocol next state; the design never holds the clock line
    always_comb
    begin
        int idx;
        idx       = 159 - 8 * int'(bcnt_q);
        state_d   = state_q;
        bit_d     = bit_q;
        sub_d     = sub_q;
        bcnt_d    = bcnt_q;
        drv_d     = drv_q;
        ack_d     = ack_q;
        tx_d      = tx_q;
        addr_d    = addr_q;
        unlock_d  = unlock_q;
        strap_d   = strap_q;
        stage_d   = stage_q;
        cmt_d     = cmt_q;
        cidx_d    = cidx_q;
        csub_d    = csub_q;
        mem_wr    = '0;
        // strap taken once after reset, never again
        if (strap_q != CSP_STRAP_DONE)
        begin
            strap_d = strap_q + 2'h1;
            if (strap_q == CSP_STRAP_TAKE)
                addr_d = sel_s_q ? CSP_ADDR_SEL_HI : CSP_ADDR_SEL_LO;
        end
        // commit a complete data set, one word per cycle
        if (cmt_q)
        begin
            mem_wr.we   = 1'b1;
            mem_wr.addr = {csub_q, cidx_q};
            mem_wr.data = cword;
            if (cidx_q == 3'h0 && csub_q == CSP_SUB_UNLOCK)
                unlock_d = (cword == CSP_UNLOCK_VALUE);
            if (cidx_q == 3'h0 && csub_q == CSP_SUB_BUS_ADDR && unlock_q)
            begin
                addr_d   = cword[6:0];
                unlock_d = 1'b0;
            end
            if (({2'b00, cidx_q} + 5'h01) * 5'h04 >= set_size(csub_q))
                cmt_d = 1'b0;
            else
                cidx_d = cidx_q + 3'h1;
        end
        // start and stop drop any partial set by resetting the count
        if (start_ev)
        begin
            state_d = CSP_ADDR;
            bit_d   = 4'h0;
            bcnt_d  = 5'h00;
            ack_d   = 1'b0;
            drv_d   = 1'b0;
        end
        else if (stop_ev)
        begin
            state_d = CSP_IDLE;
            bcnt_d  = 5'h00;
            ack_d   = 1'b0;
            drv_d   = 1'b0;
        end
        else if (scl_rise && state_q != CSP_IDLE)
        begin
            bit_d = (bit_q == CSP_BIT_ACK) ? 4'h0 : bit_q + 4'h1;
            if (bit_q == CSP_BIT_LAST)
            begin
                case (state_q)
                    CSP_ADDR:
                    begin
                        if (shift_q[7:1] == addr_q)
                        begin
                            ack_d   = 1'b1;
                            bcnt_d  = 5'h00;
                            state_d = shift_q[0] ? CSP_RD : CSP_SUB;
                        end
                        else
                            state_d = CSP_IGNORE;
                    end
                    CSP_SUB:
                    begin
                        sub_d   = shift_q;
                        bcnt_d  = 5'h00;
                        ack_d   = 1'b1;
                        state_d = CSP_WR;
                    end
                    CSP_WR:
                    begin
                        stage_d[idx -: 8] = shift_q;
                        ack_d = 1'b1;
                        if (bcnt_q + 5'h01 == set_size(sub_q))
                        begin
                            cmt_d  = 1'b1;
                            cidx_d = 3'h0;
                            csub_d = sub_q;
                            sub_d  = sub_q + 8'h01;
                            bcnt_d = 5'h00;
                        end
                        else
                            bcnt_d = bcnt_q + 5'h01;
                    end
                    default:
                    begin
                        ack_d = 1'b0;
                    end
                endcase
            end
            else if (bit_q == CSP_BIT_ACK)
            begin
                ack_d = 1'b0;
                // master answer to a byte we sent
                if (state_q == CSP_RD && !ack_q)
                begin
                    if (sda_s_q)
                        state_d = CSP_IGNORE;
                    else if (bcnt_q + 5'h01 == set_size(sub_q))
                    begin
                        sub_d  = sub_q + 8'h01;
                        bcnt_d = 5'h00;
                    end
                    else
                        bcnt_d = bcnt_q + 5'h01;
                end
            end
        end
        else if (scl_fall)
        begin
            // data line changes only while the clock is low
            if (bit_q == CSP_BIT_ACK)
                drv_d = ack_q;
            else if (state_q == CSP_RD && bit_q == 4'h0)
            begin
                tx_d  = rd_byte;
                drv_d = ~rd_byte[7];
            end
            else if (state_q == CSP_RD)
                drv_d = ~tx_q[3'(7 - int'(bit_q))];
            else
                drv_d = 1'b0;
        end
    end
    // protocol registers; only the address has a non-zero reset value
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= CSP_IDLE;
            addr_q  <= CSP_ADDR_SEL_HI;
            {bit_q, sub_q, bcnt_q, drv_q, ack_q, tx_q}         <= '0;
            {unlock_q, strap_q, stage_q, cmt_q, cidx_q, csub_q} <= '0;
        end
        else
        begin
            state_q <= state_d;
            {bit_q, sub_q, bcnt_q, drv_q, ack_q}  <= {bit_d, sub_d, bcnt_d, drv_d, ack_d};
            {tx_q, addr_q, unlock_q, strap_q}     <= {tx_d, addr_d, unlock_d, strap_d};
            {stage_q, cmt_q, cidx_q, csub_q}      <= {stage_d, cmt_d, cidx_d, csub_d};
        end
    end
    // storage for the register and coefficient space
    csp_regmem u_mem (
        .i_clk_sys (i_clk_sys),
        .i_wr      (mem_wr),
        .i_raddr   ({sub_q, bcnt_q[4:2]}),
        .o_rdata   (rdata)
    );
    // open drain: only ever pull low
    assign o_sda      = 1'b0;
    assign o_sda_oe_n = ~drv_q;
    assign o_bus_addr = addr_q;

    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    AST_START_ADDR: assert property (start_ev |=> state_q == CSP_ADDR && bit_q == 4'h0)
        else $error("start did not open address phase");
    AST_STOP_IDLE: assert property (stop_ev |=> state_q == CSP_IDLE && !drv_q)
        else $error("stop did not return to idle");
    AST_FOREIGN_ADDR: assert property (scl_rise && bit_q == CSP_BIT_LAST &&
        state_q == CSP_ADDR && shift_q[7:1] != addr_q && !start_ev && !stop_ev
        |=> state_q == CSP_IGNORE && !ack_q)
        else $error("foreign address was answered");
    AST_STRAP: assert property (strap_q == CSP_STRAP_TAKE
        |=> addr_q == ($past(sel_s_q) ? CSP_ADDR_SEL_HI : CSP_ADDR_SEL_LO))
        else $error("strap address wrong");
    AST_ACK_DRIVE: assert property (scl_fall && bit_q == CSP_BIT_ACK && ack_q && !start_ev
        && !stop_ev |=> drv_q ##1 (drv_q throughout (!scl_fall)[*2]))
        else $error("acknowledge not held low");
    AST_SHORT_DROP: assert property ((start_ev || stop_ev) && state_q == CSP_WR && !cmt_q
        |=> !cmt_q [*4])
        else $error("partial set committed");
    AST_SEQ_ADVANCE: assert property ($rose(cmt_q) |-> sub_q == csub_q + 8'h01
        && bcnt_q == 5'h00)
        else $error("subaddress did not advance");
    AST_NARROW_ONE: assert property ($rose(cmt_q) && csub_q <= CSP_SUB_NARROW_END
        |=> !cmt_q)
        else $error("narrow set longer than one byte");
    AST_ADDR_CHANGE: assert property (cmt_q && cidx_q == 3'h0 && csub_q == CSP_SUB_BUS_ADDR
        && unlock_q |=> addr_q == $past(cword[6:0]) && !unlock_q)
        else $error("bus address not moved");
    AST_READ_ZERO: assert property (sub_q == CSP_SUB_BUS_ADDR && bcnt_q[1:0] != 2'h3
        |-> rd_byte == 8'h00)
        else $error("unused read bits not zero");
    AST_READ_NACK: assert property (scl_rise && bit_q == CSP_BIT_ACK && state_q == CSP_RD
        && !ack_q && sda_s_q && !start_ev && !stop_ev |=> state_q == CSP_IGNORE)
        else $error("read continued after nack");
    COV_WRITE_COMMIT: cover property ($rose(cmt_q) && csub_q > CSP_SUB_NARROW_END);
    COV_READ_DATA: cover property (state_q == CSP_RD && scl_fall && bit_q == 4'h0);
    COV_ADDR_MOVE: cover property ($changed(addr_q) && strap_q == CSP_STRAP_DONE);
    COV_FOREIGN: cover property (state_q == CSP_IGNORE);
endmodule // csp_slave

/* File: src/csp_pkg.sv */
// shared constants and types for the control bus slave port
package csp_pkg;
    // bus addresses
    localparam logic [6:0]  CSP_ADDR_SEL_HI  = 7'h36;
    localparam logic [6:0]  CSP_ADDR_SEL_LO  = 7'h34;
    // subaddress map
    localparam logic [7:0]  CSP_SUB_NARROW_END = 8'h1F;
    localparam logic [7:0]  CSP_SUB_UNLOCK     = 8'hF8;
    localparam logic [7:0]  CSP_SUB_BUS_ADDR   = 8'hF9;
    localparam logic [7:0]  CSP_SUB_BIQUAD_LO  = 8'h29;
    localparam logic [7:0]  CSP_SUB_BIQUAD_HI  = 8'h36;
    localparam logic [31:0] CSP_UNLOCK_VALUE   = 32'hF9A5_A5A5;
    // bytes per subaddress data set
    localparam logic [4:0]  CSP_SIZE_NARROW = 5'h01;
    localparam logic [4:0]  CSP_SIZE_WORD   = 5'h04;
    localparam logic [4:0]  CSP_SIZE_BIQUAD = 5'h14;
    // bit counter values of the last data bit and the acknowledge slot
    localparam logic [3:0]  CSP_BIT_ACK  = 4'h8;
    localparam logic [3:0]  CSP_BIT_LAST = 4'h7;
    // strap is sampled once the pin synchroniser has filled
    localparam logic [1:0]  CSP_STRAP_TAKE = 2'h2;
    localparam logic [1:0]  CSP_STRAP_DONE = 2'h3;
    // storage: subaddress and word index
    localparam int          CSP_MEM_AW = 11;
    localparam int          CSP_MEM_DW = 32;

    typedef enum logic [2:0] {
        CSP_IDLE   = 3'b000,
        CSP_ADDR   = 3'b001,
        CSP_SUB    = 3'b010,
        CSP_WR     = 3'b011,
        CSP_RD     = 3'b100,
        CSP_IGNORE = 3'b101
    } csp_state_t;

    typedef struct packed {
        logic                  we;
        logic [CSP_MEM_AW-1:0] addr;
        logic [CSP_MEM_DW-1:0] data;
    } csp_mem_wr_t;
endpackage

/* File: src/csp_regmem.sv */
// register and coefficient storage with registered read data
`timescale 1ns/1ps
module csp_regmem
    import csp_pkg::*;
#(
    parameter int AW = CSP_MEM_AW,
    parameter int DW = CSP_MEM_DW
)
(
    // clock
    input  wire logic          i_clk_sys,
    // write port
    input  wire csp_mem_wr_t   i_wr,
    // read port
    input  wire logic [AW-1:0] i_raddr,
    output logic      [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // no reset on the array: contents are undefined until written
    always_ff @(posedge i_clk_sys)
    begin
        if (i_wr.we)
        begin
            mem[i_wr.addr[AW-1:0]] <= i_wr.data;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule // csp_regmem

/* File: verif/csp_host_model.sv */
// bus master model that drives the two-wire link from the host side
`timescale 1ns/1ps
module csp_host_model
(
    // resolved data line level
    input  wire logic i_sda,
    // bus clock and data pull-down
    output logic      o_scl,
    output logic      o_sda_low
);
    logic tck;

    // 48 ns tick base; each bit-slot clock phase is four ticks, well over six system cycles
    initial
    begin
        tck       = 1'b0;
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end
    always #24 tck = ~tck;

    // wait some ticks, then step off the edge
    task automatic tk(input int n);
        repeat (n) @(posedge tck);
        #1;
    endtask

    // start or repeated start: data falls while the clock is high
    task automatic start();
        o_sda_low = 1'b0;
        tk(2);
        o_scl = 1'b1;
        tk(4);
        o_sda_low = 1'b1;
        tk(4);
        o_scl = 1'b0;
    endtask

    // stop: data rises while the clock is high, then the clock stands high
    task automatic stop();
        o_sda_low = 1'b1;
        tk(2);
        o_scl = 1'b1;
        tk(4);
        o_sda_low = 1'b0;
        tk(4);
    endtask

    // one clock period; data changes only in the low phase
    task automatic bit_slot(input logic drv, output logic smp);
        tk(2);
        o_sda_low = ~drv;
        tk(2);
        o_scl = 1'b1;
        tk(2);
        smp = i_sda;
        tk(2);
        o_scl = 1'b0;
    endtask

    // byte out msb first, then a released slot for the acknowledge
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(b[i], s);
        bit_slot(1'b1, ack);
    endtask

    // byte in msb first, then our acknowledge or the final nack
    task automatic rd_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(1'b1, b[i]);
        bit_slot(nack, s);
    endtask
endmodule // csp_host_model

/* File: verif/test_control_bus_slave_port.sv */
// self-checking bench for the control bus slave port with a byte-level reference
`timescale 1ns/1ps
module test_control_bus_slave_port;
    import csp_pkg::*;

    logic       i_clk_sys;
    logic       i_nrst;
    logic       i_addr_sel;
    logic       scl;
    logic       m_low;
    logic       sda;
    logic       o_sda;
    logic       o_sda_oe_n;
    logic [6:0] o_bus_addr;
    logic       ack;
    int         fails;
    int         compares;
    logic [7:0] ref_b [int];
    logic [7:0] dq [$];

    // system clock
    always #10 i_clk_sys = ~i_clk_sys;

    // wired-and data line; the pull-up wins when nobody pulls low
    assign sda = ~m_low & (o_sda_oe_n | o_sda);

    csp_slave i_dut (
        .i_clk_sys  (i_clk_sys),
        .i_nrst     (i_nrst),
        .i_scl_clk  (scl),
        .i_sda      (sda),
        .o_sda      (o_sda),
        .o_sda_oe_n (o_sda_oe_n),
        .i_addr_sel (i_addr_sel),
        .o_bus_addr (o_bus_addr)
    );

    csp_host_model i_host (
        .i_sda     (sda),
        .o_scl     (scl),
        .o_sda_low (m_low)
    );

    // bytes per data set, by subaddress range
    function automatic int set_size(input int s);
        if (s <= CSP_SUB_NARROW_END)
            return CSP_SIZE_NARROW;
        if (s >= CSP_SUB_BIQUAD_LO && s <= CSP_SUB_BIQUAD_HI)
            return CSP_SIZE_BIQUAD;
        return CSP_SIZE_WORD;
    endfunction

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("BAD at %0t: %s", $time, msg);
        end
    endtask

    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic rnd_fill(input int n);
        dq = {};
        repeat (n) dq.push_back(8'($urandom()));
    endtask

    // write dq from sub; only whole sets reach the reference, a partial tail is lost
    task automatic xfer_wr(input logic [6:0] a, input logic [7:0] sub, input bit ok,
                           input bit rs);
        int         s;
        logic [7:0] set_b [$];
        s = sub;
        i_host.start();
        i_host.wr_byte({a, 1'b0}, ack);
        chk(ack === ~ok, "address acknowledge");
        i_host.wr_byte(sub, ack);
        chk(ack === ~ok, "subaddress acknowledge");
        foreach (dq[i])
        begin
            i_host.wr_byte(dq[i], ack);
            chk(ack === ~ok, "data acknowledge");
            set_b.push_back(dq[i]);
            if (set_b.size() == set_size(s))
            begin
                if (ok)
                    foreach (set_b[j])
                        ref_b[s * 64 + j] = set_b[j];
                set_b = {};
                s++;
            end
        end
        if (!rs)
            i_host.stop();
    endtask

    // set the subaddress, restart for reading, nack the last byte
    task automatic xfer_rd(input logic [6:0] a, input logic [7:0] sub, input int n);
        int         s;
        int         k;
        logic [7:0] b;
        s = sub;
        k = 0;
        dq = {};
        xfer_wr(a, sub, 1'b1, 1'b1);
        i_host.start();
        i_host.wr_byte({a, 1'b1}, ack);
        chk(ack === 1'b0, "read address acknowledge");
        for (int i = 0; i < n; i++)
        begin
            i_host.rd_byte(i == n - 1, b);
            chk(b === ref_b[s * 64 + k], "read data byte");
            k++;
            if (k == set_size(s))
            begin
                k = 0;
                s++;
            end
        end
        i_host.stop();
    endtask

    // hang guard: a run past the limit ends as a mismatch
    initial
    begin
        repeat (100000) @(posedge i_clk_sys);
        fails++;
        results();
    end

    // main sequence
    initial
    begin
        i_clk_sys  = 1'b0;
        i_nrst     = 1'b0;
        i_addr_sel = 1'b1;
        fails      = 0;
        compares   = 0;
        void'($urandom(32'hc552_e8c9));
        repeat (4) @(posedge i_clk_sys);
        #2 i_nrst = 1'b1;
        repeat (12) @(posedge i_clk_sys);
        // strap moves after power-up; address must not follow it
        #2 i_addr_sel = 1'b0;
        repeat (12) @(posedge i_clk_sys);
        chk(o_bus_addr === CSP_ADDR_SEL_HI, "strap high address");
        $display("test strap done");

        // narrow single byte, then a run across the narrow/word boundary
        dq = {8'h5a};
        xfer_wr(CSP_ADDR_SEL_HI, 8'h05, 1'b1, 1'b0);
        rnd_fill(6);
        xfer_wr(CSP_ADDR_SEL_HI, 8'h1e, 1'b1, 1'b0);
        xfer_rd(CSP_ADDR_SEL_HI, 8'h1e, 6);
        xfer_rd(CSP_ADDR_SEL_HI, 8'h05, 1);
        $display("test narrow done");

        // word sets: a partial tail must leave the older word intact
        rnd_fill(4);
        xfer_wr(CSP_ADDR_SEL_HI, 8'h41, 1'b1, 1'b0);
        rnd_fill(6);
        xfer_wr(CSP_ADDR_SEL_HI, 8'h40, 1'b1, 1'b0);
        xfer_rd(CSP_ADDR_SEL_HI, 8'h40, 8);
        $display("test word done");

        // filter section: a short set cut by a repeated start is dropped
        rnd_fill(20);
        xfer_wr(CSP_ADDR_SEL_HI, CSP_SUB_BIQUAD_LO, 1'b1, 1'b0);
        rnd_fill(8);
        xfer_wr(CSP_ADDR_SEL_HI, CSP_SUB_BIQUAD_LO, 1'b1, 1'b1);
        xfer_rd(CSP_ADDR_SEL_HI, CSP_SUB_BIQUAD_LO, 20);
        $display("test filter done");

        // foreign address: nothing acknowledged, nothing stored
        rnd_fill(2);
        xfer_wr(7'h35, 8'h05, 1'b0, 1'b0);
        xfer_rd(CSP_ADDR_SEL_HI, 8'h05, 1);
        $display("test foreign done");

        // unlock, then move the bus address
        dq = {8'hf9, 8'ha5, 8'ha5, 8'ha5};
        xfer_wr(CSP_ADDR_SEL_HI, CSP_SUB_UNLOCK, 1'b1, 1'b0);
        dq = {8'h00, 8'h00, 8'h00, 8'h38};
        xfer_wr(CSP_ADDR_SEL_HI, CSP_SUB_BUS_ADDR, 1'b1, 1'b0);
        chk(o_bus_addr === 7'h38, "address after change");
        dq = {};
        xfer_wr(CSP_ADDR_SEL_HI, 8'h05, 1'b0, 1'b0);
        xfer_rd(7'h38, CSP_SUB_BUS_ADDR, 4);
        $display("test address change done");

        // reset again with the strap low
        @(posedge i_clk_sys);
        #2 i_nrst = 1'b0;
        repeat (2) @(posedge i_clk_sys);
        #2 i_nrst = 1'b1;
        repeat (12) @(posedge i_clk_sys);
        chk(o_bus_addr === CSP_ADDR_SEL_LO, "strap low address");
        dq = {};
        xfer_wr(CSP_ADDR_SEL_HI, 8'h05, 1'b0, 1'b0);
        xfer_rd(CSP_ADDR_SEL_LO, 8'h05, 1);
        $display("test strap low done");
        results();
    end
endmodule // test_control_bus_slave_port
